//--- pda_app_regs.sv
// APB slave for the demo application space: control, counter, switches, memory.
// Assumes APB3/4 master; paddr[31:28] carries the region number.
`timescale 1ns/100ps
module pda_app_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [7:0]  board_switch_bank,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             count_running
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [31:0] reload;
        logic [7:0]  sw;
        logic [31:0] rdata;
        logic        ready;
        logic        running;
    } pda_regs_state_t;

    pda_regs_state_t state_reg;
    pda_regs_state_t state_next;

    logic        in_region;
    logic [27:0] ofs;
    logic        hit_mem;
    logic        wr_access;
    logic        rd_access;
    logic        cnt_start;
    logic        cnt_stop;
    logic        cnt_run;
    logic [31:0] cnt_value;
    logic [31:0] mem_rdata;
    logic [3:0]  strb_eff;

    ////////////////////////////////////////////////////////////////////////
    assign in_region = (paddr[31:28] == pda_pkg::REGION_APP);
    assign ofs       = {paddr[27:2], 2'b00};
    assign hit_mem   = in_region && ofs >= pda_pkg::OFS_MEM_BASE
                       && ofs < pda_pkg::OFS_MEM_BASE + 28'(pda_pkg::MEM_BYTES);
    // Setup cycle does the work, access phase answers: zero wait states
    assign wr_access = psel && !penable && pwrite;
    assign rd_access = psel && !penable && !pwrite;
    // APB3 masters without pstrb should tie it to 4'hF
    assign strb_eff  = pstrb;

    assign cnt_start = wr_access && in_region && ofs == pda_pkg::OFS_CTRL
                       && pstrb[0] && pwdata[pda_pkg::CTRL_RUN_BIT];
    assign cnt_stop  = wr_access && in_region && ofs == pda_pkg::OFS_CTRL
                       && pstrb[0] && !pwdata[pda_pkg::CTRL_RUN_BIT];

    pda_down_counter #(
        .WIDTH (32)
    ) u_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (cnt_start),
        .stop    (cnt_stop),
        .reload  (state_reg.reload),
        .running (cnt_run),
        .count   (cnt_value)
    );

    pda_block_memory #(
        .WORDS (pda_pkg::MEM_WORDS),
        .AW    (12)
    ) u_mem (
        .pclk  (pclk),
        .index (paddr[13:2]),
        .wr    (wr_access && hit_mem),
        .strb  (strb_eff),
        .wdata (pwdata),
        .rdata (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next         = state_reg;
        state_next.sw      = board_switch_bank;
        state_next.running = cnt_run;
        state_next.ready   = psel && !penable;
        if (wr_access && in_region && ofs == pda_pkg::OFS_RELOAD) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b]) begin
                    state_next.reload[8*b +: 8] = pwdata[8*b +: 8];
                end
            end
        end
        if (rd_access) begin
            state_next.rdata = 32'h00000000;
            if (hit_mem) begin
                state_next.rdata = mem_rdata;
            end else if (in_region) begin
                case (ofs)
                    pda_pkg::OFS_CTRL:   state_next.rdata = {31'h0, cnt_run};
                    pda_pkg::OFS_RELOAD: state_next.rdata = state_reg.reload;
                    pda_pkg::OFS_COUNT:  state_next.rdata = cnt_value;
                    pda_pkg::OFS_SWITCH: state_next.rdata = {24'h0, state_reg.sw};
                    default:             state_next.rdata = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg        <= '0;
            state_reg.reload <= pda_pkg::RELOAD_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata        = state_reg.rdata;
    assign pready        = state_reg.ready;
    assign pslverr       = 1'b0;
    assign count_running = state_reg.running;
endmodule : pda_app_regs

//--- pda_pkg.sv
// Constants shared by the demo application register block.
// Assumes an APB master on a 32-bit bus and a 100 MHz pclk.
// Notes on behaviour
// - A 32-bit counter counts down while running and software starts and stops it.
// - The counter advances on the block clock, the same one that drives the link core side.
// - Starting the counter loads the reload value first, not the old count.
// - A writable reload register holds the start value of the counter.
// - The current count is readable at any time, running or stopped.
// - An 8-bit read-only register shows the live board switch positions.
// - Accesses of 8, 16 and 32 bits are supported, sized by byte strobes.
// - The block memory sits in region 1 from offset 0x1000.
// - Only region 1 decodes any content.
// - Any byte pattern written to the memory reads back unchanged.
// - Each memory byte can be read or written on its own.
package pda_pkg;
    localparam logic [3:0]  REGION_APP   = 4'h1;
    localparam logic [27:0] OFS_CTRL     = 28'h0000000;
    localparam logic [27:0] OFS_RELOAD   = 28'h0000004;
    localparam logic [27:0] OFS_COUNT    = 28'h0000008;
    localparam logic [27:0] OFS_SWITCH   = 28'h000000C;
    localparam logic [27:0] OFS_MEM_BASE = 28'h0001000;
    localparam int          MEM_BYTES    = 16384;
    localparam int          MEM_WORDS    = MEM_BYTES / 4;
    localparam logic [31:0] RELOAD_RST   = 32'h00000000;
    localparam logic [31:0] COUNT_RST    = 32'h00000000;
    localparam int          CTRL_RUN_BIT = 0;
endpackage : pda_pkg

//--- pda_down_counter.sv
// 32-bit down counter with run control and reload on start.
// Assumes one clock; start is a one-cycle pulse.
`timescale 1ns/100ps
module pda_down_counter #(
    parameter int WIDTH = 32
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic [WIDTH-1:0] reload,
    output logic                  running,
    output logic      [WIDTH-1:0] count
);
    typedef struct packed {
        logic             run;
        logic [WIDTH-1:0] cnt;
    } pda_cnt_state_t;

    pda_cnt_state_t state_reg;
    pda_cnt_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (start) begin
            state_next.run = 1'b1;
            state_next.cnt = reload;
        end else if (stop) begin
            state_next.run = 1'b0;
        end else if (state_reg.run) begin
            state_next.cnt = state_reg.cnt - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign running = state_reg.run;
    assign count   = state_reg.cnt;
endmodule : pda_down_counter

//--- pda_block_memory.sv
// Word-wide flip-flop memory with per-byte write strobes.
// Assumes index already decoded; read data follows index in the same cycle.
`timescale 1ns/100ps
module pda_block_memory #(
    parameter int WORDS = 4096,
    parameter int AW    = 12
) (
    input  wire logic          pclk,
    input  wire logic [AW-1:0] index,
    input  wire logic          wr,
    input  wire logic [3:0]    strb,
    input  wire logic [31:0]   wdata,
    output logic      [31:0]   rdata
);
    // No reset: contents are undefined until written, as in real RAM
    logic [31:0] mem [WORDS];

    always_ff @(posedge pclk) begin
        for (int b = 0; b < 4; b++) begin
            if (wr && strb[b]) begin
                mem[index][8*b +: 8] <= wdata[8*b +: 8];
            end
        end
    end

    assign rdata = mem[index];
endmodule : pda_block_memory

//--- pda_app_regs_checker.sv
// Assertions on the demo application APB slave ports.
// Bound to every instance of the slave at the foot of this file.
`timescale 1ns/100ps
module pda_app_regs_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [7:0]  board_switch_bank,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        count_running
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic rd = psel && !penable && !pwrite;
    wire logic ctl = psel && !penable && pwrite && paddr[31:2] == 30'h04000000 && pstrb[0];
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready late");
    property p_acc; pready |-> penable && $past(psel) && !$past(penable); endproperty
    a_acc: assert property (p_acc) else $error("stray pready");
    property p_err; pready |-> !pslverr; endproperty
    a_err: assert property (p_err) else $error("error response");
    property p_sw; rd && paddr == 32'h1000000C && $stable(board_switch_bank) && $past(presetn)
        |=> prdata == {24'h0, $past(board_switch_bank)}; endproperty
    a_sw: assert property (p_sw) else $error("switch value wrong");
    property p_bar; rd && paddr[31:28] != 4'h1 |=> prdata == 32'h0; endproperty
    a_bar: assert property (p_bar) else $error("other region not zero");
    property p_gap; rd && paddr[31:4] == 28'h1000001 |=> prdata == 32'h0; endproperty
    a_gap: assert property (p_gap) else $error("unmapped not zero");
    property p_go; ctl && pwdata[0] |-> ##[1:3] count_running; endproperty
    a_go: assert property (p_go) else $error("counter not started");
    property p_halt; ctl && !pwdata[0] |-> ##[1:3] !count_running; endproperty
    a_halt: assert property (p_halt) else $error("counter not stopped");
endmodule : pda_app_regs_checker
bind pda_app_regs pda_app_regs_checker pda_app_regs_checker_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .board_switch_bank(board_switch_bank), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_running(count_running));

//--- pda_apb_master.sv
// APB master model standing in for the link core request path.
// Assumes one pclk; callers enter on a rising edge.
`timescale 1ns/100ps
module pda_apb_master (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb
);
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = 71'h0;
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
              input logic [3:0] s, output logic [31:0] r);
        @(posedge pclk);
        // Region in 31:28, offset below; strobes sized to the access
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'h2, w, a, d, s};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        // Flip released lines so stale values never pass for data
        {psel, penable, paddr, pwdata, pstrb} <= {2'h0, ~a, ~d, ~s};
    endtask : xfer
endmodule : pda_apb_master

//--- testbench.sv
// Self-checking bench for the demo application APB slave.
// Drives it through the APB master model; the checker binds itself.
`timescale 1ns/100ps
module testbench;
    typedef struct packed {logic w; logic [31:0] a; logic [31:0] v; logic [3:0] s;} pda_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, count_running;
    logic [31:0] paddr, pwdata, prdata, r, c1, c2;
    logic [3:0]  pstrb;
    logic [7:0]  board_switch_bank;
    int          num_errors = 0, cmp_count = 0;
    pda_row_t rows[13] = '{
        '{1'h0,32'h10000008,32'h0,4'hF}, '{1'h1,32'h10001000,32'hAAAAAAAA,4'hF},
        '{1'h1,32'h10001000,32'h000000FF,4'h1}, '{1'h1,32'h10001002,32'h00010000,4'h4},
        '{1'h1,32'h20001000,32'h0,4'hF}, '{1'h0,32'h10001000,32'hAA01AAFF,4'hF},
        '{1'h1,32'h10004FFC,32'h55555555,4'hF}, '{1'h1,32'h10004FFE,32'h01FF0000,4'hC},
        '{1'h0,32'h10004FFC,32'h01FF5555,4'hF}, '{1'h1,32'h10000010,32'hFFFFFFFF,4'hF},
        '{1'h0,32'h10000010,32'h0,4'hF}, '{1'h0,32'h20001000,32'h0,4'hF},
        '{1'h1,32'h10000004,32'h00000100,4'hF}};
    pda_app_regs pda_app_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .board_switch_bank(board_switch_bank), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_running(count_running));
    pda_apb_master pda_apb_master_i (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task bus(input logic w, input logic [31:0] a, input logic [31:0] v, output logic [31:0] q);
        pda_apb_master_i.xfer(w, a, v, 4'hF, q);
    endtask : bus
    task give_verdict();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin pclk = 1'h0; forever #5 pclk = ~pclk; end
    initial begin repeat (2000) @(posedge pclk); num_errors++; give_verdict(); end
    initial begin
        presetn = 1'h0;
        board_switch_bank = 8'h00;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        foreach (rows[i]) begin
            pda_apb_master_i.xfer(rows[i].w, rows[i].a, rows[i].v, rows[i].s, r);
            if (!rows[i].w) chk("row", rows[i].v, r);
        end
        for (int k = 0; k < 2; k++) begin
            board_switch_bank <= 8'h5A ^ {8{k[0]}};
            bus(1'h0, 32'h1000000C, 32'h0, r);
            chk("switch", {24'h0, 8'h5A ^ {8{k[0]}}}, r);
        end
        bus(1'h1, 32'h10000000, 32'h1, r);
        bus(1'h0, 32'h10000008, 32'h0, c1);
        bus(1'h0, 32'h10000008, 32'h0, c2);
        chk("run", 32'h1, {31'h0, count_running});
        chk("load", 32'h1, {31'h0, c1 <= 32'h100 && c1 > 32'hF0});
        chk("fall", 32'h1, {31'h0, c2 < c1});
        bus(1'h1, 32'h10000000, 32'h0, r);
        bus(1'h0, 32'h10000008, 32'h0, c1);
        repeat (8) @(posedge pclk);
        bus(1'h0, 32'h10000008, 32'h0, c2);
        chk("held", c1, c2);
        chk("stop", 32'h0, {31'h0, count_running});
        bus(1'h1, 32'h10000000, 32'h1, r);
        bus(1'h0, 32'h10000008, 32'h0, c2);
        chk("reload", 32'h1, {31'h0, c2 > c1});
        bus(1'h0, 32'h10000000, 32'h0, r);
        chk("ctrl", 32'h1, r);
        // Reset in mid-run with the counter going
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        chk("rst_run", 32'h0, {31'h0, count_running});
        chk("rst_rdy", 32'h0, {31'h0, pready});
        chk("rst_rdata", 32'h0, prdata);
        presetn <= 1'h1;
        bus(1'h0, 32'h10000004, 32'h0, r);
        chk("rst_reload", pda_pkg::RELOAD_RST, r);
        bus(1'h0, 32'h10000008, 32'h0, r);
        chk("rst_count", pda_pkg::COUNT_RST, r);
        bus(1'h0, 32'h10000000, 32'h0, r);
        chk("rst_ctrl", 32'h0, r);
        chk("err", 32'h0, {31'h0, pslverr});
        give_verdict();
    end
endmodule : testbench
